// file: rtl/irq_prio_pkg.sv
package irq_prio_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] SP2_PRIO_OFS = 8'h00;
  localparam logic [7:0] CAP_PRIO_OFS = 8'h04;

  // Field positions (low bit of each 3-bit field)
  localparam int SP2_FAULT_LSB = 0;
  localparam int SP2_EVENT_LSB = 4;
  localparam int CAP_CH3_LSB = 4;
  localparam int CAP_CH4_LSB = 8;
  localparam int CAP_CH5_LSB = 12;

  // Width of one priority field
  localparam int PRIO_W = 3;

  // Level codes
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  localparam logic [2:0] PRIO_MIN = 3'h1;

  // Implemented-bit masks for the two registers
  localparam logic [15:0] SP2_PRIO_MASK = 16'h0077;
  localparam logic [15:0] CAP_PRIO_MASK = 16'h7770;

  // Number of sources fed to arbitration
  localparam int NUM_SRC = 5;

  // Source indices
  localparam int SRC_SP2_FAULT = 0;
  localparam int SRC_SP2_EVENT = 1;
  localparam int SRC_CAP_CH3 = 2;
  localparam int SRC_CAP_CH4 = 3;
  localparam int SRC_CAP_CH5 = 4;

  // Per-source priority levels as held in the registers
  typedef struct packed {
    logic [2:0] capture_ch5_priority;
    logic [2:0] capture_ch4_priority;
    logic [2:0] capture_ch3_priority;
    logic [2:0] serial_port2_event_priority;
    logic [2:0] serial_port2_fault_priority;
  } prio_cfg_s;

  // One pending AHB data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_phase_s;

endpackage

// file: rtl/src_prio_gate.sv
`timescale 1ns/100ps
// Turns one source's flag, enable and priority into a request for arbitration
module src_prio_gate
(
  // Clock and reset, used by the checks only
  input wire logic clk,
  input wire logic rst_n,
  // Source state
  input wire logic flag,
  input wire logic enable,
  input wire logic [2:0] level,
  // Towards arbitration
  output logic req,
  output logic [2:0] req_level
);

  // A zero level masks the source whatever flag and enable say
  always_comb
  begin
    req = flag && enable && (level != irq_prio_pkg::PRIO_OFF);
    // Level equals the binary code: 1 lowest up to 7 highest
    req_level = req ? level : irq_prio_pkg::PRIO_OFF;
  end

  a_level_top: assert property (@(posedge clk) disable iff (!rst_n)
    (flag && enable && level == irq_prio_pkg::PRIO_MAX) |-> req && req_level == 3'h7)
    else $error("code 111 did not give level 7");

  a_level_ascend: assert property (@(posedge clk) disable iff (!rst_n)
    (flag && enable && level >= irq_prio_pkg::PRIO_MIN) |-> req_level == level)
    else $error("requested level differs from field code");

  a_source_off: assert property (@(posedge clk) disable iff (!rst_n)
    (level == irq_prio_pkg::PRIO_OFF) |-> !req && req_level == 3'h0)
    else $error("disabled source raised a request");

endmodule

// file: rtl/irq_priority_cfg_bank.sv
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module irq_priority_cfg_bank
#(
  parameter int ADDR_W = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Source flags and enables from the peripherals
  input wire logic [irq_prio_pkg::NUM_SRC-1:0] src_flag,
  input wire logic [irq_prio_pkg::NUM_SRC-1:0] src_enable,
  // Towards arbitration
  output irq_prio_pkg::prio_cfg_s prio_cfg,
  output logic [irq_prio_pkg::NUM_SRC-1:0] src_req,
  output logic [irq_prio_pkg::NUM_SRC-1:0][2:0] src_req_level
);

  // The decoder needs at least the byte offsets of both registers
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // Register storage, only implemented bits are kept
  logic [2:0] sp2_event_reg;
  logic [2:0] sp2_fault_reg;
  logic [2:0] cap_ch5_reg;
  logic [2:0] cap_ch4_reg;
  logic [2:0] cap_ch3_reg;
  // Data phase bookkeeping
  irq_prio_pkg::ahb_phase_s phase_reg;
  // Read data, held in flops
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  // Address phase acceptance
  logic addr_take;
  logic wr_now;
  // Image of each register as seen this cycle
  logic [15:0] sp2_image;
  logic [15:0] cap_image;

  // Returns 1 for the first register, 2 for the second, 0 when unmapped
  function automatic logic [1:0] reg_sel(input logic [7:0] ofs);
    logic [1:0] s;
    s = 2'h0;
    if (ofs == irq_prio_pkg::SP2_PRIO_OFS)
    begin
      s = 2'h1;
    end
    else if (ofs == irq_prio_pkg::CAP_PRIO_OFS)
    begin
      s = 2'h2;
    end
    return s;
  endfunction

  // Zero wait states and only OKAY answers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // A transfer is taken on NONSEQ or SEQ while the bus is ready
  assign addr_take = hsel && hready && htrans[1];
  // A write lands in the data phase that follows its address phase
  assign wr_now = phase_reg.valid && phase_reg.write;

  // Register images; unused positions are constant zero
  always_comb
  begin
    sp2_image = 16'h0000;
    sp2_image[irq_prio_pkg::SP2_EVENT_LSB +: 3] = sp2_event_reg;
    sp2_image[irq_prio_pkg::SP2_FAULT_LSB +: 3] = sp2_fault_reg;
    cap_image = 16'h0000;
    cap_image[irq_prio_pkg::CAP_CH5_LSB +: 3] = cap_ch5_reg;
    cap_image[irq_prio_pkg::CAP_CH4_LSB +: 3] = cap_ch4_reg;
    cap_image[irq_prio_pkg::CAP_CH3_LSB +: 3] = cap_ch3_reg;
  end

  // Remember the address phase for the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= '0;
    end
    else if (hready)
    begin
      phase_reg.valid <= addr_take;
      phase_reg.write <= hwrite;
      phase_reg.addr <= haddr[7:0];
    end
  end

  // Serial port 2 fields; other bits of the word are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp2_event_reg <= irq_prio_pkg::PRIO_RESET;
      sp2_fault_reg <= irq_prio_pkg::PRIO_RESET;
    end
    else if (wr_now && reg_sel(phase_reg.addr) == 2'h1)
    begin
      sp2_event_reg <= hwdata[irq_prio_pkg::SP2_EVENT_LSB +: 3];
      sp2_fault_reg <= hwdata[irq_prio_pkg::SP2_FAULT_LSB +: 3];
    end
  end

  // Capture channel fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_ch5_reg <= irq_prio_pkg::PRIO_RESET;
      cap_ch4_reg <= irq_prio_pkg::PRIO_RESET;
      cap_ch3_reg <= irq_prio_pkg::PRIO_RESET;
    end
    else if (wr_now && reg_sel(phase_reg.addr) == 2'h2)
    begin
      cap_ch5_reg <= hwdata[irq_prio_pkg::CAP_CH5_LSB +: 3];
      cap_ch4_reg <= hwdata[irq_prio_pkg::CAP_CH4_LSB +: 3];
      cap_ch3_reg <= hwdata[irq_prio_pkg::CAP_CH3_LSB +: 3];
    end
  end

  // Read data is built at the address phase so it stands from a flop.
  // A write still in its data phase to the same register is forwarded,
  // otherwise a write followed at once by a read would return stale data.
  always_comb
  begin
    hrdata_next = 32'h0000_0000;
    unique case (reg_sel(haddr[7:0]))
      2'h1:
      begin
        if (wr_now && reg_sel(phase_reg.addr) == 2'h1)
        begin
          hrdata_next[15:0] = hwdata[15:0] & irq_prio_pkg::SP2_PRIO_MASK;
        end
        else
        begin
          hrdata_next[15:0] = sp2_image;
        end
      end
      2'h2:
      begin
        if (wr_now && reg_sel(phase_reg.addr) == 2'h2)
        begin
          hrdata_next[15:0] = hwdata[15:0] & irq_prio_pkg::CAP_PRIO_MASK;
        end
        else
        begin
          hrdata_next[15:0] = cap_image;
        end
      end
      // Unmapped offsets read as zero
      default:
      begin
        hrdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data flop, loaded only for an accepted read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata_reg <= 32'h0000_0000;
    end
    else if (addr_take && !hwrite)
    begin
      hrdata_reg <= hrdata_next;
    end
  end

  // Levels handed to arbitration straight from the flops
  always_comb
  begin
    prio_cfg.capture_ch5_priority = cap_ch5_reg;
    prio_cfg.capture_ch4_priority = cap_ch4_reg;
    prio_cfg.capture_ch3_priority = cap_ch3_reg;
    prio_cfg.serial_port2_event_priority = sp2_event_reg;
    prio_cfg.serial_port2_fault_priority = sp2_fault_reg;
  end

  // Per-source request gating, indexed as the package source numbers
  logic [irq_prio_pkg::NUM_SRC-1:0][2:0] level_vec;
  assign level_vec = prio_cfg;

  for (genvar i = 0; i < irq_prio_pkg::NUM_SRC; i++)
  begin : g_src
    src_prio_gate u_gate
    (
      .clk(clk),
      .rst_n(rst_n),
      .flag(src_flag[i]),
      .enable(src_enable[i]),
      .level(level_vec[i]),
      .req(src_req[i]),
      .req_level(src_req_level[i])
    );
  end

  // Helper: high in the first cycle after reset release
  logic first_cyc_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_cyc_reg <= 1'b1;
    end
    else
    begin
      first_cyc_reg <= 1'b0;
    end
  end

  // A write to the capture register, address then data phase
  sequence cap_write_seq;
    addr_take && hwrite && reg_sel(haddr[7:0]) == 2'h2 ##1 1'b1;
  endsequence

  a_ch5_field: assert property (@(posedge clk) disable iff (!rst_n)
    cap_write_seq |=> cap_ch5_reg == $past(hwdata[14:12]))
    else $error("channel five field not written from bits 14:12");

  a_ch4_field: assert property (@(posedge clk) disable iff (!rst_n)
    cap_write_seq |=> cap_ch4_reg == $past(hwdata[10:8]))
    else $error("channel four field not written from bits 10:8");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
    hrdata[31:15] == 17'h0 && hrdata[11] == 1'b0 && hrdata[3] == 1'b0 && hrdata[7] == 1'b0)
    else $error("unimplemented bit read as one");

  a_read_image: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_take && !hwrite && reg_sel(haddr[7:0]) == 2'h2 && !wr_now)
      |=> hrdata[15:0] == $past(cap_image))
    else $error("capture register read mismatch");

  a_reset_mid: assert property (@(posedge clk) disable iff (!rst_n)
    first_cyc_reg |-> prio_cfg == {5{3'h4}})
    else $error("priority fields not at level four after reset");

  a_ready_okay: assert property (@(posedge clk) disable iff (!rst_n)
    hreadyout && !hresp)
    else $error("slave stalled or answered an error");

  a_sp2_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_now && reg_sel(phase_reg.addr) == 2'h1) |=> $stable(sp2_image))
    else $error("serial port register changed without a write");

  // Reads of each register taken while no write is pending.
  // The forwarded case is left out so the image compare stays simple.
  sequence sp2_read_seq;
    addr_take && !hwrite && reg_sel(haddr[7:0]) == 2'h1 && !wr_now;
  endsequence

  sequence cap_read_seq;
    addr_take && !hwrite && reg_sel(haddr[7:0]) == 2'h2 && !wr_now;
  endsequence

  // A write to the serial port register, address then data phase
  sequence sp2_write_seq;
    addr_take && hwrite && reg_sel(haddr[7:0]) == 2'h1 ##1 1'b1;
  endsequence

  // Gaps of the serial port register read back as zero
  a_sp2_gaps: assert property (@(posedge clk) disable iff (!rst_n)
    sp2_read_seq |=> hrdata[15:7] == 9'h0 && hrdata[3] == 1'b0)
    else $error("serial port register gap read as one");

  // The low nibble and the gaps of the capture register hold no field
  a_cap_gaps: assert property (@(posedge clk) disable iff (!rst_n)
    cap_read_seq |=> hrdata[3:0] == 4'h0 && hrdata[7] == 1'b0 && hrdata[11] == 1'b0)
    else $error("capture register gap read as one");

  // Serial port fields read back as stored
  a_sp2_image: assert property (@(posedge clk) disable iff (!rst_n)
    sp2_read_seq |=> hrdata[6:4] == $past(sp2_event_reg)
      && hrdata[2:0] == $past(sp2_fault_reg))
    else $error("serial port register read mismatch");

  // Serial port fields take their own slots of the written word
  a_sp2_fields: assert property (@(posedge clk) disable iff (!rst_n)
    sp2_write_seq |=> sp2_event_reg == $past(hwdata[6:4])
      && sp2_fault_reg == $past(hwdata[2:0]))
    else $error("serial port fields not written from their slots");

  // Unmapped offsets read as zero, whatever was written there
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_take && !hwrite && reg_sel(haddr[7:0]) == 2'h0) |=> hrdata == 32'h0)
    else $error("unmapped offset read as nonzero");

  // Capture fields only move on a write to their own register
  a_cap_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr_now && reg_sel(phase_reg.addr) == 2'h2) |=> $stable(cap_image))
    else $error("capture register changed without a write");

endmodule

// file: dv/irq_priority_cfg_bank_bench.sv
`timescale 1ns/100ps
module irq_priority_cfg_bank_bench;
  // Clock, reset and bus master drive
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // Source side
  logic [4:0] src_flag = 5'h0;
  logic [4:0] src_enable = 5'h0;
  irq_prio_pkg::prio_cfg_s prio_cfg;
  logic [4:0] src_req;
  logic [4:0][2:0] src_req_level;
  // Scoreboard notes, counters and random state
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rng = 32'd70429;
  logic [31:0] d;
  // Read expectations, taken off by the bus monitor
  logic [31:0] rd_exp_q[$];
  logic rd_pend = 1'b0;
  logic [4:0] req;
  logic [2:0] lv;

  // 8 ns clock
  always #4 clk = ~clk;

  // Hready comes back from the one slave; hsize is always a word
  irq_priority_cfg_bank i_irq_priority_cfg_bank (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .src_flag(src_flag), .src_enable(src_enable), .prio_cfg(prio_cfg), .src_req(src_req),
    .src_req_level(src_req_level));

  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Single compare point
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expectation goes in first so the monitor never sees a lone result
  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    exp_q.push_back(exp);
    got_q.push_back(got);
  endtask

  // Monitor: pairs each result with the oldest expectation
  initial
  forever
  begin
    wait (got_q.size() > 0);
    check(got_q.pop_front(), exp_q.pop_front());
  end

  // Bus monitor: read data stands at the ready edge after its address phase
  always @(posedge clk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      // A read nobody expected counts against the run
      if (rd_exp_q.size() > 0)
        check(hrdata, rd_exp_q.pop_front());
      else
        check(hrdata, ~hrdata);
    end
    if (hreadyout === 1'b1)
      rd_pend <= hsel && htrans[1] && !hwrite;
  end

  // Verdict and end of run
  task automatic results();
    // Expectations left over mean a result never appeared
    if (rd_exp_q.size() != 0 || got_q.size() != 0)
      err_count++;
    $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Waits for ready at a rising edge; a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_count++;
        results();
      end
      @(posedge clk);
    end
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask

  // Read and note what should come back
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    note({17'h0, prio_cfg}, 32'h4924);
    rst_n <= 1'b1;
    rd_chk(irq_prio_pkg::SP2_PRIO_OFS, 32'h44);
    rd_chk(irq_prio_pkg::CAP_PRIO_OFS, 32'h4440);
    $display("test reset_values done");
    // Random full words: only the field bits may stick
    repeat (4)
    begin
      d = rnd();
      bus(1'b1, irq_prio_pkg::SP2_PRIO_OFS, d);
      rd_chk(irq_prio_pkg::SP2_PRIO_OFS, {16'h0, d[15:0] & 16'h0077});
      bus(1'b1, irq_prio_pkg::CAP_PRIO_OFS, ~d);
      rd_chk(irq_prio_pkg::CAP_PRIO_OFS, {16'h0, ~d[15:0] & 16'h7770});
    end
    bus(1'b1, 8'h08, 32'hffffffff);
    rd_chk(8'h08, 32'h0);
    // The unmapped write must not have reached either register
    rd_chk(irq_prio_pkg::SP2_PRIO_OFS, {16'h0, d[15:0] & 16'h0077});
    rd_chk(irq_prio_pkg::CAP_PRIO_OFS, {16'h0, ~d[15:0] & 16'h7770});
    $display("test masking done");
    // Channel five and channel four capture fields each land alone in their own slot
    bus(1'b1, irq_prio_pkg::SP2_PRIO_OFS, 32'h0);
    bus(1'b1, irq_prio_pkg::CAP_PRIO_OFS, 32'h7000);
    #1;
    note({17'h0, prio_cfg}, 32'h7000);
    @(posedge clk);
    bus(1'b1, irq_prio_pkg::CAP_PRIO_OFS, 32'h0500);
    #1;
    note({17'h0, prio_cfg}, 32'h0a00);
    @(posedge clk);
    $display("test field_positions done");
    // Every code on every source, random flags, enables random on sources 1 and 3 and forced on for 0, 2 and 4
    for (int c = 0; c < 8; c++)
    begin
      lv = c[2:0];
      d = rnd();
      bus(1'b1, irq_prio_pkg::SP2_PRIO_OFS, {25'h0, lv, 1'b0, lv});
      bus(1'b1, irq_prio_pkg::CAP_PRIO_OFS, {17'h0, lv, 1'b0, lv, 1'b0, lv, 4'h0});
      src_flag <= d[4:0];
      src_enable <= d[9:5] | 5'h15;
      @(posedge clk);
      #1;
      req = d[4:0] & (d[9:5] | 5'h15) & {5{lv != 3'h0}};
      note({27'h0, src_req}, {27'h0, req});
      for (int s = 0; s < 5; s++)
        note({29'h0, src_req_level[s]}, req[s] ? {29'h0, lv} : 32'h0);
      @(posedge clk);
    end
    $display("test level_codes done");
    // Second reset in mid-run restores defaults
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(irq_prio_pkg::SP2_PRIO_OFS, 32'h44);
    rd_chk(irq_prio_pkg::CAP_PRIO_OFS, 32'h4440);
    $display("test second_reset done");
    #1;
    results();
  end
endmodule
